/* verilog/xcvr_glb_pkg.sv */
// Package with register map, field layouts, reset values and timing constants
package xcvr_glb_pkg;

  // Printed offsets are register indexes; byte address is four times the index
  localparam logic [7:0] IDX_GPIO = 8'h06;
  localparam logic [7:0] IDX_REF_SEL = 8'h07;
  localparam logic [7:0] IDX_LINK_SUMMARY = 8'h09;
  localparam logic [7:0] IDX_TIMER_EN = 8'h0a;
  localparam logic [7:0] IDX_TIMER_FLAG = 8'h0b;
  localparam logic [7:0] IDX_CNT_PORT = 8'h0e;
  localparam logic [7:0] IDX_CNT_DATA = 8'h0f;
  localparam logic [7:0] IDX_BACKPLANE = 8'h10;
  localparam logic [7:0] IDX_JITTER_CFG = 8'h21;
  localparam logic [7:0] IDX_JITTER_IND = 8'h38;
  localparam logic [7:0] IDX_LOSS_FALLBACK = 8'h3e;

  // Reset values
  localparam logic [3:0] RST_GPIO = 4'h3;
  localparam logic [5:0] RST_REF_SEL = 6'h00;
  localparam logic [6:0] RST_CNT_PORT = 7'h00;
  localparam logic [4:0] RST_BACKPLANE = 5'h16;
  localparam logic [5:0] RST_JITTER_CFG = 6'h00;

  // Field positions
  localparam int GPIO_DIR0 = 0;
  localparam int GPIO_DIR1 = 1;
  localparam int GPIO_LEVEL0 = 2;
  localparam int GPIO_LEVEL1 = 3;
  localparam int REF_FIRST_LSB = 0;
  localparam int REF_SECOND_LSB = 3;
  localparam int CNT_INDEX_LSB = 0;
  localparam int CNT_LINK_LSB = 5;

  // Highest counter byte index that exists
  localparam logic [3:0] CNT_INDEX_LAST = 4'hb;

  // One-second timer
  localparam int TIMER_PERIOD_NS = 1000000000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TIMER_CYCLES = TIMER_PERIOD_NS / CLK_PERIOD_NS;

  // Jitter FIFO depths and the guard windows that go with them
  localparam logic [7:0] DEPTH_128 = 8'h80;
  localparam logic [7:0] DEPTH_64 = 8'h40;
  localparam logic [7:0] DEPTH_32 = 8'h20;
  localparam logic [7:0] GUARD_128 = 8'h04;
  localparam logic [7:0] GUARD_64 = 8'h03;
  localparam logic [7:0] GUARD_32 = 8'h02;

  typedef struct packed {
    logic shared_rx_clock_sel;
    logic rx_multiplex_en;
    logic tx_mux_bus_select;
    logic shared_tx_clock_sel;
    logic tx_multiplex_en;
  } backplane_cfg_t;

  typedef struct packed {
    logic jitter_peak_hold_sel;
    logic jitter_bandwidth_widen;
    logic tx_jitter_atten_en;
    logic [1:0] depth_sel;
    logic low_bandwidth;
  } jitter_cfg_t;

  typedef struct packed {
    logic [2:0] counter_link_select;
    logic [3:0] index;
  } counter_port_t;

endpackage

/* verilog/ref_clock_mux.sv */
// Reference clock output selector with loss-of-signal fallback
`timescale 1ns/100ps
module ref_clock_mux (
  input wire logic clk,
  input wire logic [7:0] recovered_clk,
  input wire logic [7:0] link_los,
  input wire logic [2:0] link_sel,
  input wire logic loss_fallback_high_sel,
  output logic ref_clock_out
);

  // loss fallback
  // Pure gating: a clock path must not be retimed by the clock it carries
  always_comb
  begin
    if (link_los[link_sel])
    begin
      ref_clock_out = loss_fallback_high_sel ? 1'b1 : clk;
    end
    else
    begin
      ref_clock_out = recovered_clk[link_sel];
    end
  end

endmodule

/* verilog/jitter_monitor.sv */
// Transmit jitter pointer distance indicator and bandwidth widening
`timescale 1ns/100ps
module jitter_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire xcvr_glb_pkg::jitter_cfg_t cfg,
  input wire logic [6:0] fifo_distance,
  output logic [6:0] jitter_pointer_distance,
  output logic widen_active,
  output logic atten_bypass
);

  logic [7:0] depth;
  logic [7:0] guard;
  logic in_window;

  // Depth code 10 and 11 both mean the shallowest FIFO
  always_comb
  begin
    case (cfg.depth_sel)
      2'b00:
      begin
        depth = xcvr_glb_pkg::DEPTH_128;
        guard = xcvr_glb_pkg::GUARD_128;
      end
      2'b01:
      begin
        depth = xcvr_glb_pkg::DEPTH_64;
        guard = xcvr_glb_pkg::GUARD_64;
      end
      default:
      begin
        depth = xcvr_glb_pkg::DEPTH_32;
        guard = xcvr_glb_pkg::GUARD_32;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      jitter_pointer_distance <= 7'h00;
    else if (!cfg.jitter_peak_hold_sel || fifo_distance > jitter_pointer_distance)
      jitter_pointer_distance <= fifo_distance;
  end

  assign in_window = ({1'b0, fifo_distance} <= guard) ||
                     ({1'b0, fifo_distance} >= depth - guard);
  assign widen_active = cfg.tx_jitter_atten_en && cfg.jitter_bandwidth_widen && in_window;
  assign atten_bypass = !cfg.tx_jitter_atten_en;

endmodule

/* verilog/xcvr_global_regs.sv */
// Global control and status register bank of the eight-link transceiver
//
// Notes on behaviour
// - Output pin 0 drives its level bit
// - Input pin 0 level bit reads pin
// - Pin 1 direction: 0 output, 1 input
// - Pin 0 direction: 0 output, 1 input
// - Second reference output carries selected link clock
// - First reference output carries selected link clock
// - On loss: master clock or high level
// - Eight read-only per-link pending flags
// - Timer interrupt only when enabled and expired
// - Free one-second timer sets expiry flag
// - Expiry flag cleared only by writing one
// - Link select chooses counter link
// - Index selects one of twelve counter bytes
// - Data register shows addressed counter byte
// - Shared receive clock from link one
// - Receive interface multiplex enable
// - Transmit bus select: 1 A, 0 B
// - Shared transmit clock from link one
// - Transmit interface multiplex enable
// - Test bit 0: indication tracks distance
// - Test bit 1: indication holds peak
// - Widen bandwidth near FIFO limits
// - Attenuator works only when enabled
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module xcvr_global_regs #(
  parameter int TIMER_CYCLES = xcvr_glb_pkg::TIMER_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // General pins
  input wire logic [1:0] gpio_in,
  output logic [1:0] gpio_out,
  output logic [1:0] gpio_oe,
  // Reference clock outputs
  input wire logic [7:0] recovered_clk,
  input wire logic [7:0] link_los,
  output logic first_ref_clock_out,
  output logic second_ref_clock_out,
  // Interrupts
  input wire logic [7:0] link_irq_pending,
  output logic timer_irq,
  // Performance monitor counters
  output xcvr_glb_pkg::counter_port_t counter_port,
  input wire logic [7:0] counter_byte,
  // Backplane options
  output xcvr_glb_pkg::backplane_cfg_t backplane_cfg,
  // Transmit jitter attenuator
  input wire logic [6:0] fifo_distance,
  output xcvr_glb_pkg::jitter_cfg_t jitter_cfg,
  output logic jitter_widen_active,
  output logic jitter_atten_bypass
);

  // ********************************************************
  // Register storage
  // ********************************************************
  logic [3:0] gpio_ctrl;
  logic [5:0] ref_sel;
  logic loss_fallback_high_sel;
  logic second_timer_irq_en;
  logic second_timer_expired;
  logic [7:0] counter_access_data;
  logic [6:0] jitter_pointer_distance;
  logic [26:0] timer_count;
  logic timer_tick;

  // ********************************************************
  // Bus slave state
  // ********************************************************
  logic addr_valid;
  logic read_req;
  logic [7:0] addr_idx;
  logic wr_pend;
  logic [7:0] wr_idx;
  logic wr_commit;
  logic [7:0] wdat;
  logic read_stall;

  // Address phase decode; writes count only as word accesses inside the low window, reads at any size
  assign addr_valid = hsel && htrans[1] && hready;
  assign addr_idx = haddr[9:2];
  assign read_req = addr_valid && !hwrite;

  // A read behind a write waits one cycle so it sees the written value
  assign read_stall = wr_pend && hsel && htrans[1] && !hwrite;
  assign hreadyout = !read_stall;
  assign hresp = 1'b0;

  // Write address phase captured for the data phase
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend <= addr_valid && hwrite && hsize == 3'b010 && haddr[31:10] == 22'h0;
      wr_idx <= addr_idx;
    end
    else
    begin
      // The stalled cycle has committed the write, so the stall cannot repeat
      wr_pend <= 1'b0;
    end
  end

  // Write data stand from the first data phase cycle, wait state or not
  assign wr_commit = wr_pend;
  assign wdat = hwdata[7:0];

  // ********************************************************
  // Read data
  // ********************************************************
  // reserved bits zero
  function automatic logic [7:0] read_value(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == xcvr_glb_pkg::IDX_GPIO)
    begin
      v[xcvr_glb_pkg::GPIO_DIR0] = gpio_ctrl[xcvr_glb_pkg::GPIO_DIR0];
      v[xcvr_glb_pkg::GPIO_DIR1] = gpio_ctrl[xcvr_glb_pkg::GPIO_DIR1];
      v[xcvr_glb_pkg::GPIO_LEVEL0] = gpio_ctrl[xcvr_glb_pkg::GPIO_DIR0] ?
        gpio_in[0] : gpio_ctrl[xcvr_glb_pkg::GPIO_LEVEL0];
      v[xcvr_glb_pkg::GPIO_LEVEL1] = gpio_ctrl[xcvr_glb_pkg::GPIO_DIR1] ?
        gpio_in[1] : gpio_ctrl[xcvr_glb_pkg::GPIO_LEVEL1];
    end
    else if (idx == xcvr_glb_pkg::IDX_REF_SEL)
      v[5:0] = ref_sel;
    else if (idx == xcvr_glb_pkg::IDX_LINK_SUMMARY)
      v = link_irq_pending;
    else if (idx == xcvr_glb_pkg::IDX_TIMER_EN)
      v[0] = second_timer_irq_en;
    else if (idx == xcvr_glb_pkg::IDX_TIMER_FLAG)
      v[0] = second_timer_expired;
    else if (idx == xcvr_glb_pkg::IDX_CNT_PORT)
      v = {counter_port.counter_link_select, 1'b0, counter_port.index};
    else if (idx == xcvr_glb_pkg::IDX_CNT_DATA)
      v = counter_access_data;
    else if (idx == xcvr_glb_pkg::IDX_BACKPLANE)
      v[4:0] = backplane_cfg;
    else if (idx == xcvr_glb_pkg::IDX_JITTER_CFG)
      v[5:0] = jitter_cfg;
    else if (idx == xcvr_glb_pkg::IDX_JITTER_IND)
      v[6:0] = jitter_pointer_distance;
    else if (idx == xcvr_glb_pkg::IDX_LOSS_FALLBACK)
      v[0] = loss_fallback_high_sel;
    return v;
  endfunction

  // Read data registered at the address phase, stands through the data phase
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hrdata <= 32'h0;
    else if (read_req)
      hrdata <= (haddr[31:10] == 22'h0) ? {24'h0, read_value(addr_idx)} : 32'h0;
  end

  // ********************************************************
  // General pins
  // ********************************************************
  // output level write
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      gpio_ctrl <= xcvr_glb_pkg::RST_GPIO;
    else if (wr_commit && wr_idx == xcvr_glb_pkg::IDX_GPIO)
    begin
      gpio_ctrl[xcvr_glb_pkg::GPIO_DIR0] <= wdat[xcvr_glb_pkg::GPIO_DIR0];
      gpio_ctrl[xcvr_glb_pkg::GPIO_DIR1] <= wdat[xcvr_glb_pkg::GPIO_DIR1];
      if (!gpio_ctrl[xcvr_glb_pkg::GPIO_DIR0])
        gpio_ctrl[xcvr_glb_pkg::GPIO_LEVEL0] <= wdat[xcvr_glb_pkg::GPIO_LEVEL0];
      if (!gpio_ctrl[xcvr_glb_pkg::GPIO_DIR1])
        gpio_ctrl[xcvr_glb_pkg::GPIO_LEVEL1] <= wdat[xcvr_glb_pkg::GPIO_LEVEL1];
    end
  end

  assign gpio_oe[0] = !gpio_ctrl[xcvr_glb_pkg::GPIO_DIR0];
  assign gpio_oe[1] = !gpio_ctrl[xcvr_glb_pkg::GPIO_DIR1];
  assign gpio_out = {gpio_ctrl[xcvr_glb_pkg::GPIO_LEVEL1], gpio_ctrl[xcvr_glb_pkg::GPIO_LEVEL0]};

  // ********************************************************
  // Reference clock selection
  // ********************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ref_sel <= xcvr_glb_pkg::RST_REF_SEL;
    else if (wr_commit && wr_idx == xcvr_glb_pkg::IDX_REF_SEL)
      ref_sel <= wdat[5:0];
  end

  // Loss fallback choice: 0 master clock, 1 constant high
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      loss_fallback_high_sel <= 1'b0;
    else if (wr_commit && wr_idx == xcvr_glb_pkg::IDX_LOSS_FALLBACK)
      loss_fallback_high_sel <= wdat[0];
  end

  ref_clock_mux u_first_ref (
    .clk(clk),
    .recovered_clk(recovered_clk),
    .link_los(link_los),
    .link_sel(ref_sel[xcvr_glb_pkg::REF_FIRST_LSB +: 3]),
    .loss_fallback_high_sel(loss_fallback_high_sel),
    .ref_clock_out(first_ref_clock_out)
  );

  ref_clock_mux u_second_ref (
    .clk(clk),
    .recovered_clk(recovered_clk),
    .link_los(link_los),
    .link_sel(ref_sel[xcvr_glb_pkg::REF_SECOND_LSB +: 3]),
    .loss_fallback_high_sel(loss_fallback_high_sel),
    .ref_clock_out(second_ref_clock_out)
  );

  // ********************************************************
  // One-second timer
  // ********************************************************
  // free running timer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      timer_count <= 27'h0;
    else if (timer_tick)
      timer_count <= 27'h0;
    else
      timer_count <= timer_count + 27'h1;
  end

  assign timer_tick = timer_count == 27'(TIMER_CYCLES - 1);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      second_timer_irq_en <= 1'b0;
    else if (wr_commit && wr_idx == xcvr_glb_pkg::IDX_TIMER_EN)
      second_timer_irq_en <= wdat[0];
  end

  // write one clears
  // A tick in the clearing cycle wins, so no expiry is lost
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      second_timer_expired <= 1'b0;
    else if (timer_tick)
      second_timer_expired <= 1'b1;
    else if (wr_commit && wr_idx == xcvr_glb_pkg::IDX_TIMER_FLAG && wdat[0])
      second_timer_expired <= 1'b0;
  end

  assign timer_irq = second_timer_irq_en && second_timer_expired;

  // ********************************************************
  // Counter access
  // ********************************************************
  // link select
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      counter_port <= xcvr_glb_pkg::RST_CNT_PORT;
    else if (wr_commit && wr_idx == xcvr_glb_pkg::IDX_CNT_PORT)
    begin
      counter_port.counter_link_select <= wdat[xcvr_glb_pkg::CNT_LINK_LSB +: 3];
      counter_port.index <= wdat[xcvr_glb_pkg::CNT_INDEX_LSB +: 4];
    end
  end

  // counter byte sampled
  // Indexes past the last counter byte return zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      counter_access_data <= 8'h00;
    else if (counter_port.index > xcvr_glb_pkg::CNT_INDEX_LAST)
      counter_access_data <= 8'h00;
    else
      counter_access_data <= counter_byte;
  end

  // ********************************************************
  // Backplane options
  // ********************************************************
  // shared receive clock
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      backplane_cfg <= xcvr_glb_pkg::RST_BACKPLANE;
    else if (wr_commit && wr_idx == xcvr_glb_pkg::IDX_BACKPLANE)
      backplane_cfg <= wdat[4:0];
  end

  // ********************************************************
  // Transmit jitter attenuator
  // ********************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      jitter_cfg <= xcvr_glb_pkg::RST_JITTER_CFG;
    else if (wr_commit && wr_idx == xcvr_glb_pkg::IDX_JITTER_CFG)
      jitter_cfg <= wdat[5:0];
  end

  jitter_monitor u_jitter (
    .clk(clk),
    .rst_n(rst_n),
    .cfg(jitter_cfg),
    .fifo_distance(fifo_distance),
    .jitter_pointer_distance(jitter_pointer_distance),
    .widen_active(jitter_widen_active),
    .atten_bypass(jitter_atten_bypass)
  );

endmodule

/* verif/xcvr_global_regs_sva.sv */
// Concurrent checks on the ports of the global register bank
`timescale 1ns/100ps
module xcvr_global_regs_chk #(
  parameter int TIMER_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] gpio_oe,
  input wire logic timer_irq,
  input wire xcvr_glb_pkg::counter_port_t counter_port,
  input wire xcvr_glb_pkg::backplane_cfg_t backplane_cfg,
  input wire logic [6:0] fifo_distance,
  input wire xcvr_glb_pkg::jitter_cfg_t jitter_cfg,
  input wire logic jitter_widen_active,
  input wire logic jitter_atten_bypass
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ************************************************************
  // Helper logic
  // ************************************************************
  logic wr_dphase;
  int cyc;

  // Write data phase pending; registers may only move when it completes
  always_ff @(posedge clk)
  begin
    if (!rst_n) wr_dphase <= 1'b0;
    else if (hready) wr_dphase <= hsel && htrans[1] && hwrite;
    else wr_dphase <= 1'b0;
  end

  // Cycles since reset, saturating so the counter never wraps
  always_ff @(posedge clk)
  begin
    if (!rst_n) cyc <= 0;
    else if (cyc < TIMER_CYCLES) cyc <= cyc + 1;
  end

  // ************************************************************
  // Properties
  // ************************************************************
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("slave response not okay");

  property p_one_wait;
    !hreadyout |=> hreadyout;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("more than one wait state");

  property p_rd_upper;
    hrdata[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper bits not zero");

  property p_hold;
    !wr_dphase |=> $stable(gpio_oe) && $stable(counter_port)
      && $stable(backplane_cfg) && $stable(jitter_cfg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("control output moved without a write");

  property p_timer_early;
    (cyc < TIMER_CYCLES - 2) |-> !timer_irq;
  endproperty
  a_timer_early: assert property (p_timer_early)
    else $error("timer interrupt before one period");

  property p_bypass;
    jitter_atten_bypass == !jitter_cfg.tx_jitter_atten_en;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass does not follow enable");

  property p_widen_cause;
    jitter_widen_active |-> jitter_cfg.tx_jitter_atten_en && jitter_cfg.jitter_bandwidth_widen;
  endproperty
  a_widen_cause: assert property (p_widen_cause)
    else $error("widening without enable");

  property p_widen_edge;
    jitter_cfg.tx_jitter_atten_en && jitter_cfg.jitter_bandwidth_widen
      && jitter_cfg.depth_sel == 2'b00 && (fifo_distance <= 7'd4 || fifo_distance >= 7'd124)
      |-> jitter_widen_active;
  endproperty
  a_widen_edge: assert property (p_widen_edge)
    else $error("no widening near fifo limit");

  property p_widen_mid;
    jitter_cfg.depth_sel == 2'b00 && fifo_distance > 7'd4 && fifo_distance < 7'd124
      |-> !jitter_widen_active;
  endproperty
  a_widen_mid: assert property (p_widen_mid)
    else $error("widening inside safe window");

  // Main scenarios reached
  c_timer: cover property (timer_irq);
  c_widen: cover property (jitter_widen_active);
  c_wait: cover property (!hreadyout);
endmodule

/* verif/tb_transceiver_global_control_regs.sv */
// Self-checking bench for the global register bank over AHB-Lite
`timescale 1ns/100ps
module tb_transceiver_global_control_regs;
  localparam int TC = 20;
  logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, timer_irq;
  logic first_ref_clock_out, second_ref_clock_out;
  logic jitter_widen_active, jitter_atten_bypass;
  logic [1:0] htrans, gpio_in, gpio_out, gpio_oe;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, x;
  logic [7:0] recovered_clk, link_los, link_irq_pending, counter_byte;
  logic [6:0] fifo_distance;
  xcvr_glb_pkg::counter_port_t counter_port;
  xcvr_glb_pkg::backplane_cfg_t backplane_cfg;
  xcvr_glb_pkg::jitter_cfg_t jitter_cfg;
  int miscompares, n_tests, cycles, n;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  xcvr_global_regs #(.TIMER_CYCLES(TC)) dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .recovered_clk(recovered_clk), .link_los(link_los),
    .first_ref_clock_out(first_ref_clock_out), .second_ref_clock_out(second_ref_clock_out),
    .link_irq_pending(link_irq_pending), .timer_irq(timer_irq),
    .counter_port(counter_port), .counter_byte(counter_byte), .backplane_cfg(backplane_cfg),
    .fifo_distance(fifo_distance), .jitter_cfg(jitter_cfg),
    .jitter_widen_active(jitter_widen_active), .jitter_atten_bypass(jitter_atten_bypass));

  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Ready is read at the falling edge so the rising edge sees a settled value
  task automatic wait_rdy(output logic [31:0] d);
    @(negedge clk);
    while (hreadyout !== 1'b1) @(negedge clk);
    d = hrdata;
    @(posedge clk);
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    logic [31:0] t;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    wait_rdy(t);
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_rdy(rd);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] t;
    xfer(1'b1, idx, d, t);
    // One idle edge, so the written register has settled before it is looked at
    @(posedge clk);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] t;
    xfer(1'b0, idx, 8'h00, t);
    chk($sformatf("reg %h", idx), e, t);
  endtask

  // Indication is registered, so allow one edge before reading it
  task automatic jr(input logic [6:0] d, input logic [31:0] e);
    fifo_distance <= d;
    @(posedge clk);
    rdc(xcvr_glb_pkg::IDX_JITTER_IND, e);
  endtask

  task automatic wchk(input logic [6:0] d, input logic e);
    fifo_distance <= d;
    @(negedge clk);
    chk("widen", 32'(e), 32'(jitter_widen_active));
    @(posedge clk);
  endtask

  task automatic end_of_test();
    $display("TB: tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ************************************************************
  // Clock, timeout and sequence
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Whole run is about two hundred cycles; the ceiling only catches a hang
  always @(posedge clk)
  begin
    cycles++;
    if (cycles >= 5000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  initial
  begin
    {rst_n, hwrite, htrans, haddr, hwdata, gpio_in, link_los, fifo_distance} = '0;
    {recovered_clk, link_irq_pending} = '0;
    hsel = 1'b1;
    hsize = 3'b010;
    counter_byte = 8'hc5;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(xcvr_glb_pkg::IDX_GPIO, 32'h03);
    rdc(xcvr_glb_pkg::IDX_BACKPLANE, 32'h16);
    rdc(xcvr_glb_pkg::IDX_JITTER_CFG, 32'h00);
    chk("bypass", 32'h1, 32'(jitter_atten_bypass));
    wr(xcvr_glb_pkg::IDX_BACKPLANE, 8'hff);
    rdc(xcvr_glb_pkg::IDX_BACKPLANE, 32'h1f);
    wr(xcvr_glb_pkg::IDX_BACKPLANE, 8'h09);
    chk("backplane", 32'h09, 32'(backplane_cfg));
    wr(8'h3f, 8'hff);
    rdc(8'h3f, 32'h0);
    gpio_in <= 2'b01;
    repeat (3) @(posedge clk);
    rdc(xcvr_glb_pkg::IDX_GPIO, 32'h07);
    wr(xcvr_glb_pkg::IDX_GPIO, 8'h02);
    wr(xcvr_glb_pkg::IDX_GPIO, 8'h06);
    chk("gpio", 32'h5, 32'({gpio_oe, gpio_out}));
    gpio_in <= 2'b10;
    repeat (3) @(posedge clk);
    rdc(xcvr_glb_pkg::IDX_GPIO, 32'h0e);
    wr(xcvr_glb_pkg::IDX_GPIO, 8'h00);
    chk("gpio", 32'hc, 32'({gpio_oe, gpio_out}));
    link_irq_pending <= 8'ha5;
    rdc(xcvr_glb_pkg::IDX_LINK_SUMMARY, 32'ha5);
    // every link code on both outputs
    for (int s = 0; s < 8; s++)
    begin
      wr(xcvr_glb_pkg::IDX_REF_SEL, {2'b00, s[2:0], ~s[2:0]});
      recovered_clk <= 8'h01 << s;
      @(negedge clk);
      chk("refs", 32'h2, 32'({second_ref_clock_out, first_ref_clock_out}));
      @(posedge clk);
      recovered_clk <= ~(8'h01 << s);
      @(negedge clk);
      chk("refs", 32'h1, 32'({second_ref_clock_out, first_ref_clock_out}));
      @(posedge clk);
    end
    // loss fallback to master clock, then to high level
    link_los <= 8'h80;
    recovered_clk <= 8'h00;
    // Master clock is high at this point of the cycle
    #2;
    chk("los clk", 32'h2, 32'({second_ref_clock_out, first_ref_clock_out}));
    @(posedge clk);
    wr(xcvr_glb_pkg::IDX_LOSS_FALLBACK, 8'h01);
    @(negedge clk);
    chk("los high", 32'h2, 32'({second_ref_clock_out, first_ref_clock_out}));
    @(posedge clk);
    wr(xcvr_glb_pkg::IDX_CNT_PORT, 8'h6a);
    chk("port", 32'h3a, 32'(counter_port));
    rdc(xcvr_glb_pkg::IDX_CNT_DATA, 32'hc5);
    wr(xcvr_glb_pkg::IDX_CNT_PORT, 8'hec);
    chk("port", 32'h7c, 32'(counter_port));
    rdc(xcvr_glb_pkg::IDX_CNT_DATA, 32'h00);
    wr(xcvr_glb_pkg::IDX_TIMER_EN, 8'h01);
    wr(xcvr_glb_pkg::IDX_TIMER_FLAG, 8'h01);
    n = 0;
    do
    begin
      xfer(1'b0, xcvr_glb_pkg::IDX_TIMER_FLAG, 8'h00, x);
      n++;
    end
    while (x !== 32'h1 && n < TC);
    chk("timer flag", 32'h1, x);
    chk("timer irq", 32'h1, 32'(timer_irq));
    wr(xcvr_glb_pkg::IDX_TIMER_FLAG, 8'h00);
    rdc(xcvr_glb_pkg::IDX_TIMER_FLAG, 32'h1);
    wr(xcvr_glb_pkg::IDX_TIMER_FLAG, 8'h01);
    rdc(xcvr_glb_pkg::IDX_TIMER_FLAG, 32'h0);
    chk("timer irq", 32'h0, 32'(timer_irq));
    wr(xcvr_glb_pkg::IDX_JITTER_CFG, 8'h08);
    chk("bypass", 32'h0, 32'(jitter_atten_bypass));
    jr(7'd40, 32'd40);
    jr(7'd30, 32'd30);
    wr(xcvr_glb_pkg::IDX_JITTER_CFG, 8'h28);
    jr(7'd50, 32'd50);
    jr(7'd10, 32'd50);
    wr(xcvr_glb_pkg::IDX_JITTER_CFG, 8'h18);
    wchk(7'd4, 1'b1);
    wchk(7'd5, 1'b0);
    wchk(7'd124, 1'b1);
    wr(xcvr_glb_pkg::IDX_JITTER_CFG, 8'h1a);
    wchk(7'd4, 1'b0);
    wchk(7'd61, 1'b1);
    end_of_test();
  end
endmodule

bind xcvr_global_regs xcvr_global_regs_chk #(.TIMER_CYCLES(TIMER_CYCLES)) u_chk (.clk(clk),
  .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gpio_oe(gpio_oe),
  .timer_irq(timer_irq), .counter_port(counter_port), .backplane_cfg(backplane_cfg),
  .fifo_distance(fifo_distance), .jitter_cfg(jitter_cfg),
  .jitter_widen_active(jitter_widen_active), .jitter_atten_bypass(jitter_atten_bypass));
